// ---- rtl/tcpc_cap_if.sv ----
// Link between the timer control and one capture channel
interface tcpc_cap_if;
  logic [1:0]  edge_sel;     // Edge mode field
  logic        clear_presc;  // Edge field written
  logic        enable;       // Capture mode active
  logic [15:0] timer_value;  // Timer3 count to capture
  logic        rd_lo;        // Low byte read
  logic        rd_hi;        // High byte read
  logic        wr_lo;        // Low byte write
  logic        wr_hi;        // High byte write
  logic [7:0]  wdata;        // Write byte
  logic [15:0] value;        // Held value
  logic        overflow;     // Overflow flag
  modport ctrl (output edge_sel, clear_presc, enable, timer_value,
                output rd_lo, rd_hi, wr_lo, wr_hi, wdata,
                input  value, overflow);
  modport chan (input  edge_sel, clear_presc, enable, timer_value,
                input  rd_lo, rd_hi, wr_lo, wr_hi, wdata,
                output value, overflow);
endinterface : tcpc_cap_if

// ---- rtl/tcpc_capture_channel.sv ----
// One capture channel: pin edge detect, prescaler, capture and overflow
`include "tcpc_defines.svh"
module tcpc_capture_channel (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic       i_capture_pin,
  tcpc_cap_if.chan        cap
);
  tcpc_pkg::tcpc_chan_state_t st;       // Registered state
  tcpc_pkg::tcpc_chan_state_t next_st;  // Next state
  logic rise;                           // Synchronised rising edge
  logic fall;                           // Synchronised falling edge
  logic hit;                            // Qualifying edge
  logic done;                           // Both bytes now read

  // Edge detect, prescale, capture and overflow bookkeeping
  always_comb begin
    next_st = st;
    hit = 1'b0;
    next_st.pin_sync = {st.pin_sync[0], i_capture_pin};
    next_st.pin_prev = st.pin_sync[1];
    rise = ~st.pin_prev & st.pin_sync[1];
    fall = st.pin_prev & ~st.pin_sync[1];
    case (tcpc_pkg::tcpc_edge_mode_t'(cap.edge_sel))
      tcpc_pkg::TCPC_EDGE_FALL: begin
        hit = fall; // R01 R02
      end
      tcpc_pkg::TCPC_EDGE_RISE: begin
        hit = rise; // R01 R02
      end
      tcpc_pkg::TCPC_EDGE_RISE4: begin
        if (rise) begin
          hit = (st.presc == `TCPC_PRESC_QUARTER); // R01 R02
          next_st.presc = hit ? 4'h0 : st.presc + 4'h1;
        end
      end
      default: begin
        if (rise) begin
          hit = (st.presc == `TCPC_PRESC_SIXTEENTH); // R01 R02
          next_st.presc = st.presc + 4'h1;
        end
      end
    endcase
    // Writing the edge field restarts the prescaler
    if (cap.clear_presc) begin
      next_st.presc = 4'h0; // R17
    end
    // Byte reads only count while a value is pending
    done = 1'b0;
    if (st.full) begin
      next_st.got_lo = st.got_lo | cap.rd_lo;
      next_st.got_hi = st.got_hi | cap.rd_hi;
      done = next_st.got_lo & next_st.got_hi;
    end
    // Both bytes read: release the register and clear overflow
    if (done) begin
      next_st.full = 1'b0; // R10
      next_st.ovf = 1'b0; // R18
      next_st.got_lo = 1'b0;
      next_st.got_hi = 1'b0;
    end
    // A capture in the releasing cycle wins, so no event is lost
    if (hit && cap.enable) begin
      if (!st.full || done) begin
        next_st.value = cap.timer_value; // R07
        next_st.full = 1'b1;
        next_st.ovf = 1'b0;
        next_st.got_lo = 1'b0;
        next_st.got_hi = 1'b0;
      end else begin
        next_st.ovf = 1'b1; // R08 R09 R10
      end
    end
    // Period writes only make sense outside capture mode
    if (!cap.enable && cap.wr_lo) begin
      next_st.value[7:0] = cap.wdata;
    end
    if (!cap.enable && cap.wr_hi) begin
      next_st.value[15:8] = cap.wdata;
    end
  end

  // State register
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cap.value = st.value;
  assign cap.overflow = st.ovf;
endmodule : tcpc_capture_channel

// ---- rtl/tcpc_defines.svh ----
// Register offsets, field positions and reset values of the timer control
`ifndef TCPC_DEFINES_SVH
`define TCPC_DEFINES_SVH
`define TCPC_ADDR_MODE_CTRL   8'h16
`define TCPC_ADDR_RUN_STATUS  8'h17
`define TCPC_ADDR_TIMER1      8'h18
`define TCPC_ADDR_TIMER2      8'h19
`define TCPC_ADDR_TIMER3_LO   8'h1a
`define TCPC_ADDR_TIMER3_HI   8'h1b
`define TCPC_ADDR_CAP2_LO     8'h1c
`define TCPC_ADDR_CAP2_HI     8'h1d
`define TCPC_ADDR_CAP1_LO     8'h1e
`define TCPC_ADDR_CAP1_HI     8'h1f
`define TCPC_MODE_CAP2_EDGE   7:6
`define TCPC_MODE_CAP1_EDGE   5:4
`define TCPC_MODE_WIDE        3
`define TCPC_MODE_T3_SRC      2
`define TCPC_MODE_T2_SRC      1
`define TCPC_MODE_T1_SRC      0
`define TCPC_RUN_CAP2_OVF     7
`define TCPC_RUN_CAP1_OVF     6
`define TCPC_RUN_PWM2_EN      5
`define TCPC_RUN_PWM1_EN      4
`define TCPC_RUN_CAP1_SEL     3
`define TCPC_RUN_T3_RUN       2
`define TCPC_RUN_T2_RUN       1
`define TCPC_RUN_T1_RUN       0
`define TCPC_RUN_WR_MASK      8'h3f
`define TCPC_MODE_RESET       8'h00
`define TCPC_RUN_RESET        6'h00
`define TCPC_PRESC_QUARTER    4'h3
`define TCPC_PRESC_SIXTEENTH  4'hf
`endif

// ---- rtl/tcpc_pkg.sv ----
// Types shared by the timer control and its capture channels
package tcpc_pkg;
  // Capture edge field encoding
  typedef enum logic [1:0] {
    TCPC_EDGE_FALL   = 2'b00,
    TCPC_EDGE_RISE   = 2'b01,
    TCPC_EDGE_RISE4  = 2'b10,
    TCPC_EDGE_RISE16 = 2'b11
  } tcpc_edge_mode_t;

  // State of one capture channel
  typedef struct packed {
    logic [1:0]  pin_sync;   // Two-stage pin synchroniser
    logic        pin_prev;   // Last synchronised level
    logic [3:0]  presc;      // Rising edge prescaler
    logic [15:0] value;      // Captured or period value
    logic        full;       // Unread value held
    logic        ovf;        // Overflow flag
    logic        got_lo;     // Low byte read since capture
    logic        got_hi;     // High byte read since capture
  } tcpc_chan_state_t;

  // State of the control block
  typedef struct packed {
    logic [7:0]  mode_ctrl;  // Capture and timer mode control
    logic [5:0]  run_ctrl;   // Writable run and enable bits
    logic [7:0]  timer1;     // Timer1 count
    logic [7:0]  timer2;     // Timer2 count
    logic [15:0] timer3;     // Timer3 count
    logic [7:0]  div;        // Internal tick divider
    logic [1:0]  t3_sync;    // Timer3 clock pin synchroniser
    logic        t3_prev;    // Timer3 clock pin last level
    logic [1:0]  t12_sync;   // Pair clock pin synchroniser
    logic        t12_prev;   // Pair clock pin last level
    logic [7:0]  rdata;      // Read data register
    logic        p1_o;       // Pulse pin 1 level
    logic        p1_oe_n;    // Pulse pin 1 enable, low drives
    logic        p2_o;       // Pulse pin 2 level
    logic        p2_oe_n;    // Pulse pin 2 enable, low drives
  } tcpc_state_t;
endpackage : tcpc_pkg

// ---- rtl/tcpc_timer_control.sv ----
// Timer, capture and pulse pin control with its register port
//
// Summary of operation
// R01: Capture2 edge field picks capture edge pattern
// R02: Capture1 edge field uses same encoding
// R03: Wide mode chains Timer2 above Timer1
// R04: Timer3 source bit selects pin or internal
// R05: Timer2 source bit selects pair pin
// R06: Timer1 source bit selects pair pin
// R07: Capture copies Timer3 when register is free
// R08: Unread Capture2 overflow sets flag, keeps oldest
// R09: Unread Capture1 overflow sets flag, keeps oldest
// R10: After overflow ignore captures until bytes read
// R11: Pulse2 enable forces pin to output
// R12: Pulse1 enable forces pin to output
// R13: Select bit picks Capture1 or Timer3 period
// R14: Timer3 counts only while run bit set
// R15: Software sets Timer2 run in wide mode
// R16: Timer1 run gates pair or Timer1 alone
// R17: Edge field write clears prescaler
// R18: Overflow clears after both bytes read
`include "tcpc_defines.svh"
module tcpc_timer_control #(
  parameter int INT_CLK_DIV = 1  // Clock cycles per internal tick
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output      logic [7:0] o_rdata,
  input  wire logic       i_timer3_ext_clock_pin,
  input  wire logic       i_timer_pair_ext_clock_pin,
  input  wire logic       i_capture1_pin,
  input  wire logic       i_capture2_pin,
  input  wire logic       i_pwm1_level,
  input  wire logic       i_pwm2_level,
  input  wire logic       i_port_b_out1,
  input  wire logic       i_port_b_out2,
  input  wire logic       i_port_b_direction1,
  input  wire logic       i_port_b_direction2,
  output      logic       o_pulse_out1_pin_o,
  output      logic       o_pulse_out1_pin_oe_n,
  output      logic       o_pulse_out2_pin_o,
  output      logic       o_pulse_out2_pin_oe_n,
  output      logic       o_pwm1_enable,
  output      logic       o_pwm2_enable,
  output      logic [7:0] o_timer1_count,
  output      logic [7:0] o_timer2_count,
  output      logic [15:0] o_timer3_count
);
  // The tick divider is eight bits wide
  if (INT_CLK_DIV < 1 || INT_CLK_DIV > 256) begin : g_div_check
    $error("INT_CLK_DIV must lie in 1 to 256");
  end

  localparam logic [7:0] DIV_LAST = 8'(INT_CLK_DIV - 1); // Divider wrap

  tcpc_pkg::tcpc_state_t st;       // Registered state
  tcpc_pkg::tcpc_state_t next_st;  // Next state

  tcpc_cap_if cap1 ();  // Capture1 / period channel
  tcpc_cap_if cap2 ();  // Capture2 channel

  logic int_tick;     // Internal clock tick
  logic t3_fall;      // Timer3 pin falling edge
  logic t12_fall;     // Pair pin falling edge
  logic t1_tick;      // Timer1 count source
  logic t2_tick;      // Timer2 count source
  logic t3_tick;      // Timer3 count source
  logic t1_inc;       // Timer1 increments this cycle
  logic t2_inc;       // Timer2 increments this cycle
  logic wide;         // Timer pair forms one counter
  logic cap1_mode;    // Pair register acts as Capture1
  logic wr_mode;      // Write to mode control
  logic rd_any;       // Read strobe, any address

  // Same address decode serves reads and writes
  function automatic logic hit_addr(input logic [7:0] a,
                                    input logic [7:0] want);
    hit_addr = (a == want);
  endfunction : hit_addr

  // Mode bits used throughout
  assign wide = st.mode_ctrl[`TCPC_MODE_WIDE];
  assign cap1_mode = st.run_ctrl[`TCPC_RUN_CAP1_SEL];
  assign wr_mode = i_wr && hit_addr(i_addr, `TCPC_ADDR_MODE_CTRL);
  assign rd_any = i_rd;

  // Internal tick and falling edges of the synchronised clock pins
  assign int_tick = (st.div == DIV_LAST);
  assign t3_fall = st.t3_prev & ~st.t3_sync[1];
  assign t12_fall = st.t12_prev & ~st.t12_sync[1];

  // Source selection per timer
  assign t3_tick = st.mode_ctrl[`TCPC_MODE_T3_SRC] ? t3_fall
                                                   : int_tick; // R04
  assign t2_tick = st.mode_ctrl[`TCPC_MODE_T2_SRC] ? t12_fall
                                                   : int_tick; // R05
  assign t1_tick = st.mode_ctrl[`TCPC_MODE_T1_SRC] ? t12_fall
                                                   : int_tick; // R06

  // Timer1 run bit starts the pair in wide mode, Timer1 alone otherwise
  assign t1_inc = st.run_ctrl[`TCPC_RUN_T1_RUN] & t1_tick; // R16
  // Upper byte follows the lower carry and still needs its own run bit,
  // which software must set in wide mode
  assign t2_inc = wide
    ? (t1_inc & (st.timer1 == 8'hff)
       & st.run_ctrl[`TCPC_RUN_T2_RUN])      // R03 R15 R16
    : (st.run_ctrl[`TCPC_RUN_T2_RUN] & t2_tick); // R03

  // Capture channel controls
  assign cap2.edge_sel = st.mode_ctrl[`TCPC_MODE_CAP2_EDGE]; // R01
  assign cap1.edge_sel = st.mode_ctrl[`TCPC_MODE_CAP1_EDGE]; // R02
  assign cap2.clear_presc = wr_mode; // R17
  assign cap1.clear_presc = wr_mode; // R17
  assign cap2.enable = 1'b1;
  assign cap1.enable = cap1_mode; // R13
  assign cap2.timer_value = st.timer3;
  assign cap1.timer_value = st.timer3;
  assign cap2.wdata = i_wdata;
  assign cap1.wdata = i_wdata;
  assign cap2.wr_lo = 1'b0;
  assign cap2.wr_hi = 1'b0;
  // Period bytes are software writable only in period mode
  assign cap1.wr_lo = i_wr && hit_addr(i_addr, `TCPC_ADDR_CAP1_LO);
  assign cap1.wr_hi = i_wr && hit_addr(i_addr, `TCPC_ADDR_CAP1_HI);
  // Byte reads release the capture register
  assign cap2.rd_lo = rd_any && hit_addr(i_addr, `TCPC_ADDR_CAP2_LO);
  assign cap2.rd_hi = rd_any && hit_addr(i_addr, `TCPC_ADDR_CAP2_HI);
  assign cap1.rd_lo = rd_any && cap1_mode
                      && hit_addr(i_addr, `TCPC_ADDR_CAP1_LO); // R10
  assign cap1.rd_hi = rd_any && cap1_mode
                      && hit_addr(i_addr, `TCPC_ADDR_CAP1_HI); // R10

  // Capture2 channel
  tcpc_capture_channel u_cap2 (
    .i_sys_clk     (i_sys_clk),
    .i_reset       (i_reset),
    .i_capture_pin (i_capture2_pin),
    .cap           (cap2.chan)
  );

  // Capture1 channel, doubling as the Timer3 period register
  tcpc_capture_channel u_cap1 (
    .i_sys_clk     (i_sys_clk),
    .i_reset       (i_reset),
    .i_capture_pin (i_capture1_pin),
    .cap           (cap1.chan)
  );

  // Next state: synchronisers, timers, registers and pins
  always_comb begin
    next_st = st;

    // Clock pins pass two flops before the edge detector sees them
    next_st.t3_sync = {st.t3_sync[0], i_timer3_ext_clock_pin};
    next_st.t3_prev = st.t3_sync[1];
    next_st.t12_sync = {st.t12_sync[0], i_timer_pair_ext_clock_pin};
    next_st.t12_prev = st.t12_sync[1];

    // Internal tick divider
    next_st.div = int_tick ? 8'h00 : st.div + 8'h01;

    // Timer1 and Timer2 wrap freely at their width
    if (t1_inc) begin
      next_st.timer1 = st.timer1 + 8'h01; // R03 R06 R16
    end
    if (t2_inc) begin
      next_st.timer2 = st.timer2 + 8'h01; // R03 R05
    end

    // Timer3 runs to its period unless the pair register captures
    if (st.run_ctrl[`TCPC_RUN_T3_RUN] && t3_tick) begin // R14
      if (!cap1_mode && st.timer3 == cap1.value) begin
        next_st.timer3 = 16'h0000; // R13
      end else begin
        next_st.timer3 = st.timer3 + 16'h0001; // R04 R13
      end
    end

    // Register writes; a write beats a concurrent increment
    if (i_wr) begin
      if (hit_addr(i_addr, `TCPC_ADDR_MODE_CTRL)) begin
        next_st.mode_ctrl = i_wdata;
      end else if (hit_addr(i_addr, `TCPC_ADDR_RUN_STATUS)) begin
        // Overflow bits are read only
        next_st.run_ctrl = i_wdata[5:0];
      end else if (hit_addr(i_addr, `TCPC_ADDR_TIMER1)) begin
        next_st.timer1 = i_wdata;
      end else if (hit_addr(i_addr, `TCPC_ADDR_TIMER2)) begin
        next_st.timer2 = i_wdata;
      end else if (hit_addr(i_addr, `TCPC_ADDR_TIMER3_LO)) begin
        next_st.timer3[7:0] = i_wdata;
      end else if (hit_addr(i_addr, `TCPC_ADDR_TIMER3_HI)) begin
        next_st.timer3[15:8] = i_wdata;
      end
    end

    // Read data stands for the single cycle after the strobe
    next_st.rdata = 8'h00;
    if (rd_any) begin
      if (hit_addr(i_addr, `TCPC_ADDR_MODE_CTRL)) begin
        next_st.rdata = st.mode_ctrl;
      end else if (hit_addr(i_addr, `TCPC_ADDR_RUN_STATUS)) begin
        next_st.rdata = {cap2.overflow, cap1.overflow,
                         st.run_ctrl}; // R08 R09
      end else if (hit_addr(i_addr, `TCPC_ADDR_TIMER1)) begin
        next_st.rdata = st.timer1;
      end else if (hit_addr(i_addr, `TCPC_ADDR_TIMER2)) begin
        next_st.rdata = st.timer2;
      end else if (hit_addr(i_addr, `TCPC_ADDR_TIMER3_LO)) begin
        next_st.rdata = st.timer3[7:0];
      end else if (hit_addr(i_addr, `TCPC_ADDR_TIMER3_HI)) begin
        next_st.rdata = st.timer3[15:8];
      end else if (hit_addr(i_addr, `TCPC_ADDR_CAP2_LO)) begin
        next_st.rdata = cap2.value[7:0];
      end else if (hit_addr(i_addr, `TCPC_ADDR_CAP2_HI)) begin
        next_st.rdata = cap2.value[15:8];
      end else if (hit_addr(i_addr, `TCPC_ADDR_CAP1_LO)) begin
        next_st.rdata = cap1.value[7:0];
      end else if (hit_addr(i_addr, `TCPC_ADDR_CAP1_HI)) begin
        next_st.rdata = cap1.value[15:8];
      end
      // Unmapped addresses read as zero
    end

    // Pulse pins: enable overrides the port direction bit
    if (st.run_ctrl[`TCPC_RUN_PWM1_EN]) begin
      next_st.p1_o = i_pwm1_level;
      next_st.p1_oe_n = 1'b0; // R12
    end else begin
      next_st.p1_o = i_port_b_out1;
      next_st.p1_oe_n = i_port_b_direction1; // R12
    end
    if (st.run_ctrl[`TCPC_RUN_PWM2_EN]) begin
      next_st.p2_o = i_pwm2_level;
      next_st.p2_oe_n = 1'b0; // R11
    end else begin
      next_st.p2_o = i_port_b_out2;
      next_st.p2_oe_n = i_port_b_direction2; // R11
    end
  end

  // State register; pins float as inputs while in reset
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= '0;
      st.mode_ctrl <= `TCPC_MODE_RESET;
      st.run_ctrl <= `TCPC_RUN_RESET;
      st.p1_oe_n <= 1'b1;
      st.p2_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs all come from flops
  assign o_rdata = st.rdata;
  assign o_pulse_out1_pin_o = st.p1_o;
  assign o_pulse_out1_pin_oe_n = st.p1_oe_n;
  assign o_pulse_out2_pin_o = st.p2_o;
  assign o_pulse_out2_pin_oe_n = st.p2_oe_n;
  assign o_pwm1_enable = st.run_ctrl[`TCPC_RUN_PWM1_EN];
  assign o_pwm2_enable = st.run_ctrl[`TCPC_RUN_PWM2_EN];
  assign o_timer1_count = st.timer1;
  assign o_timer2_count = st.timer2;
  assign o_timer3_count = st.timer3;
endmodule : tcpc_timer_control

// ---- tb/tb_tcpc_timer_control.sv ----
// Self-checking bench for the timer, capture and pulse pin control
module tb_tcpc_timer_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_sys_clk, i_reset, i_wr, i_rd;
  logic [7:0]  i_addr, i_wdata, o_rdata, o_timer1_count, o_timer2_count;
  logic        i_timer3_ext_clock_pin, i_timer_pair_ext_clock_pin;
  logic        i_capture1_pin, i_capture2_pin;
  logic        i_pwm1_level, i_pwm2_level, i_port_b_out1, i_port_b_out2;
  logic        i_port_b_direction1, i_port_b_direction2;
  logic        o_pulse_out1_pin_o, o_pulse_out1_pin_oe_n;
  logic        o_pulse_out2_pin_o, o_pulse_out2_pin_oe_n;
  logic        o_pwm1_enable, o_pwm2_enable;
  logic [15:0] o_timer3_count;
  logic [7:0]  rv;           // Last byte read back
  logic [15:0] w, v;         // Pair read back, value to capture
  int          fails, check_count, k;
  int          need [4] = '{1, 1, 4, 16};  // Edges per capture, by mode

  tcpc_timer_control #(.INT_CLK_DIV(1)) dut (.*);

  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  // Pulse pin side inputs wander at random once out of reset
  always @(posedge i_sys_clk) begin
    if (!i_reset) begin
      {i_pwm1_level, i_pwm2_level, i_port_b_out1, i_port_b_out2,
       i_port_b_direction1, i_port_b_direction2} <= 6'($urandom);
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk

  // One-cycle write, then an idle cycle so the strobe never re-rises at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    @(posedge i_sys_clk);
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(negedge i_sys_clk);
    rv = o_rdata;
    @(posedge i_sys_clk);
  endtask : rd

  task automatic rd16(input logic [7:0] a);
    rd(a);
    w[7:0] = rv;
    rd(a + 8'h01);
    w[15:8] = rv;
  endtask : rd16

  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 8'h01, d[15:8]);
  endtask : wr16

  // Pins: [0] capture1, [1] capture2, [2] Timer3 clock, [3] pair clock
  task automatic pins(input logic [3:0] m);
    {i_timer_pair_ext_clock_pin, i_timer3_ext_clock_pin,
     i_capture2_pin, i_capture1_pin} <= m;
    repeat (6) @(posedge i_sys_clk);  // Covers the synchroniser delay
  endtask : pins

  task automatic pulse(input logic [3:0] m);
    pins(m);
    pins(4'h0);
  endtask : pulse

  task automatic close_out();
    if (fails == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  // Hang guard
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    fails++;
    close_out();
  end

  initial begin
    void'($urandom(67985));
    {i_reset, i_port_b_direction1, i_port_b_direction2} = 3'h7;
    {i_wr, i_rd, i_addr, i_wdata} = 18'h00000;
    {i_pwm1_level, i_pwm2_level, i_port_b_out1, i_port_b_out2} = 4'h0;
    {i_capture1_pin, i_capture2_pin} = 2'b00;
    {i_timer3_ext_clock_pin, i_timer_pair_ext_clock_pin} = 2'b00;
    fails = 0;
    check_count = 0;
    repeat (16) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    @(posedge i_sys_clk);
    // Reset values, read-only status bits, an unmapped place
    rd(8'h16);
    chk(rv, 8'h00);
    wr(8'h17, 8'hc0);
    rd(8'h17);
    chk(rv, 8'h00);
    rd(8'h20);
    chk(rv, 8'h00);
    k = $urandom;
    wr(8'h16, k[7:0]);
    rd(8'h16);
    chk(rv, k[7:0]);
    // Timer3 held while stopped, then free runs through the 16-bit wrap
    wr(8'h16, 8'h00);
    wr16(8'h1a, 16'hfff0);
    rd16(8'h1a);
    chk(w, 16'hfff0);
    wr(8'h17, 8'h0c);
    repeat (20) @(posedge i_sys_clk);
    wr(8'h17, 8'h08);
    rd16(8'h1a);
    chk(w, 16'h0006);
    // Period mode: 22 steps over a period of 5 (six states)
    wr(8'h17, 8'h00);
    wr16(8'h1e, 16'h0005);
    wr16(8'h1a, 16'h0000);
    wr(8'h17, 8'h04);
    repeat (20) @(posedge i_sys_clk);
    wr(8'h17, 8'h00);
    rd16(8'h1a);
    chk(w, 16'(22 % 6));
    // Timer1/Timer2: Timer1 alone, both apart, then chained
    for (int m = 0; m < 3; m++) begin
      wr(8'h16, (m == 2) ? 8'h08 : 8'h00);
      wr(8'h18, 8'hf0);
      wr(8'h19, 8'h12);
      wr(8'h17, (m == 0) ? 8'h01 : 8'h03);
      repeat (20) @(posedge i_sys_clk);
      wr(8'h17, 8'h00);
      rd(8'h18);
      chk(rv, 8'h06);
      rd(8'h19);
      chk(rv, (m == 0) ? 8'h12 : (m == 1) ? 8'h28 : 8'h13);
    end
    // All three timers on their pin falling edges
    wr(8'h16, 8'h07);
    wr(8'h18, 8'h00);
    wr(8'h19, 8'h00);
    wr16(8'h1a, 16'h0000);
    wr(8'h17, 8'h0f);
    k = 1 + $urandom % 8;
    repeat (k) pulse(4'hc);
    wr(8'h17, 8'h08);
    rd(8'h18);
    chk(rv, 8'(k));
    rd(8'h19);
    chk(rv, 8'(k));
    rd16(8'h1a);
    chk(w, 16'(k));
    // Each edge mode on both channels; stray edges then a rewrite first
    for (int e = 0; e < 4; e++) begin
      wr(8'h16, {2'(e), 2'(e), 4'h0});
      pulse(4'h3);
      pulse(4'h3);
      rd16(8'h1c);
      rd16(8'h1e);
      wr(8'h16, {2'(e), 2'(e), 4'h0});
      wr16(8'h1a, 16'h1111);
      repeat (need[e] - 1) pulse(4'h3);
      v = 16'($urandom);
      if (e != 0) wr16(8'h1a, v);
      pins(4'h3);
      if (e == 0) wr16(8'h1a, v);
      pins(4'h0);
      rd16(8'h1c);
      chk(w, v);
      rd16(8'h1e);
      chk(w, v);
    end
    // Overflow keeps the oldest value until both bytes are read
    wr(8'h17, 8'h38);
    wr(8'h16, 8'h50);
    wr16(8'h1a, 16'h0a0a);
    pulse(4'h3);
    wr16(8'h1a, 16'h0b0b);
    pulse(4'h3);
    rd(8'h17);
    chk(rv, 8'hf8);
    rd(8'h1c);
    chk(rv, 8'h0a);
    rd(8'h1e);
    chk(rv, 8'h0a);
    wr16(8'h1a, 16'h0c0c);
    pulse(4'h3);
    rd(8'h17);
    chk(rv, 8'hf8);
    rd(8'h1d);
    chk(rv, 8'h0a);
    rd(8'h1f);
    chk(rv, 8'h0a);
    rd(8'h17);
    chk(rv, 8'h38);
    pulse(4'h3);
    rd16(8'h1c);
    chk(w, 16'h0c0c);
    rd16(8'h1e);
    chk(w, 16'h0c0c);
    close_out();
  end
endmodule : tb_tcpc_timer_control

bind tcpc_timer_control tcpc_timer_control_assertions
  #(.INT_CLK_DIV(INT_CLK_DIV)) u_chk (.*);

// ---- tb/tcpc_timer_control_assertions.sv ----
// Concurrent checks on the ports of the timer control
module tcpc_timer_control_assertions #(
  parameter int INT_CLK_DIV = 1  // Clock cycles per internal tick
) (
  input wire logic        i_sys_clk,
  input wire logic        i_reset,
  input wire logic [7:0]  i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rdata,
  input wire logic        i_pwm1_level,
  input wire logic        i_port_b_out1,
  input wire logic        i_port_b_direction1,
  input wire logic        i_pwm2_level,
  input wire logic        i_port_b_out2,
  input wire logic        i_port_b_direction2,
  input wire logic        o_pulse_out1_pin_o,
  input wire logic        o_pulse_out1_pin_oe_n,
  input wire logic        o_pulse_out2_pin_o,
  input wire logic        o_pulse_out2_pin_oe_n,
  input wire logic        o_pwm1_enable,
  input wire logic        o_pwm2_enable,
  input wire logic [7:0]  o_timer1_count,
  input wire logic [7:0]  o_timer2_count,
  input wire logic [15:0] o_timer3_count
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);

  logic [7:0]  mode;    // Shadow of the mode register
  logic [5:0]  run;     // Shadow of the writable run bits
  logic [15:0] period;  // Shadow of the period pair
  logic        t1_wr;   // Timer1 written this cycle
  logic        t2_wr;   // Timer2 written this cycle
  logic        t3_wr;   // Either Timer3 byte written this cycle

  assign t1_wr = i_wr && (i_addr == 8'h18);
  assign t2_wr = i_wr && (i_addr == 8'h19);
  assign t3_wr = i_wr && (i_addr == 8'h1a || i_addr == 8'h1b);

  // Shadows follow software writes, since the checker sees no state
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      mode   <= 8'h00;
      run    <= 6'h00;
      period <= 16'h0000;
    end else if (i_wr) begin
      case (i_addr)
        8'h16:   mode <= i_wdata;
        8'h17:   run <= i_wdata[5:0];
        8'h1e:   period[7:0] <= run[3] ? period[7:0] : i_wdata;
        8'h1f:   period[15:8] <= run[3] ? period[15:8] : i_wdata;
        default: period <= period;
      endcase
    end
  end

  // Timer1 about to roll over with the pair chained and running
  sequence s_t1_wrap;
    INT_CLK_DIV == 1 && mode[3] && !mode[0] && run[0] && run[1]
      && o_timer1_count == 8'hff && !t1_wr && !t2_wr;
  endsequence

  chk_pair_carry: assert property (s_t1_wrap |=>
    o_timer2_count == $past(o_timer2_count) + 8'h01)
    else $error("upper byte missed the carry");
  chk_pair_hold: assert property (mode[3] && o_timer1_count != 8'hff
    && !t2_wr |=> $stable(o_timer2_count))
    else $error("upper byte moved without a carry");
  chk_t3_hold: assert property (!run[2] && !t3_wr |=>
    $stable(o_timer3_count))
    else $error("stopped Timer3 moved");
  chk_t3_step: assert property (INT_CLK_DIV == 1 && run[2] && run[3]
    && !mode[2] && !t3_wr |=>
    o_timer3_count == 16'($past(o_timer3_count) + 16'h0001))
    else $error("free running Timer3 did not step");
  chk_t3_period: assert property (INT_CLK_DIV == 1 && run[2] && !run[3]
    && !mode[2] && !t3_wr && o_timer3_count == period |=>
    o_timer3_count == 16'h0000)
    else $error("Timer3 ran past its period");
  chk_t1_hold: assert property (!run[0] && !t1_wr |=>
    $stable(o_timer1_count))
    else $error("stopped Timer1 moved");
  chk_pin1_drive: assert property (o_pwm1_enable && $past(o_pwm1_enable)
    |-> !o_pulse_out1_pin_oe_n && o_pulse_out1_pin_o == $past(i_pwm1_level))
    else $error("pulse pin 1 not driven by the waveform");
  chk_pin1_port: assert property (!o_pwm1_enable && !$past(o_pwm1_enable)
    |-> o_pulse_out1_pin_oe_n == $past(i_port_b_direction1)
    && o_pulse_out1_pin_o == $past(i_port_b_out1))
    else $error("pulse pin 1 ignores the port setting");
  chk_pin2_drive: assert property (o_pwm2_enable && $past(o_pwm2_enable)
    |-> !o_pulse_out2_pin_oe_n && o_pulse_out2_pin_o == $past(i_pwm2_level))
    else $error("pulse pin 2 not driven by the waveform");
  chk_pin2_port: assert property (!o_pwm2_enable
    && !$past(o_pwm2_enable)
    |-> o_pulse_out2_pin_oe_n == $past(i_port_b_direction2)
    && o_pulse_out2_pin_o == $past(i_port_b_out2))
    else $error("pulse pin 2 ignores the port setting");
  chk_run_read: assert property (i_rd && i_addr == 8'h17 |=>
    o_rdata[5:0] == $past(run))
    else $error("run bits read back wrong");
endmodule : tcpc_timer_control_assertions
